// ---- fcad_params.svh ----
// constants for the flash command address decode block
// assumes one 100 MHz clock and a synchronous active-high reset
`ifndef FCAD_PARAMS_SVH
`define FCAD_PARAMS_SVH
`define FCAD_OFS_W 14
`define FCAD_UNLOCK1_OFS 14'h1554
`define FCAD_UNLOCK2_OFS 14'h2AA8
`define FCAD_UNLOCK1_DATA 8'hA8
`define FCAD_UNLOCK2_DATA 8'h54
`define FCAD_CODE_RESET 8'hF0
`define FCAD_CODE_PROG 8'hA0
`define FCAD_CODE_ERASE 8'h80
`define FCAD_PAGE_SEL_HI 15
`define FCAD_PAGE_SEL_LO 14
`define FCAD_EXTENDED_SEGMENT_PREFIX_MAX 3'h4
`define FCAD_FLASH_BASE_RST 24'h000000
`define FCAD_FLASH_LIMIT_RST 24'h07FFFF
`endif

// ---- fcad_pkg.sv ----
// types shared by the flash command address decode files
// assumes the params header is included where constants are used
package fcad_pkg;
	typedef enum logic [2:0] {
		FCAD_READ = 3'b000,
		FCAD_UNL1 = 3'b001,
		FCAD_UNL2 = 3'b010,
		FCAD_PROG = 3'b011,
		FCAD_ERASE = 3'b100
	} fcad_state_t;
	typedef logic [23:0] fcad_addr_t;
endpackage

// ---- fcad_addr_if.sv ----
// carrier between the decoder and its address former
// assumes both ends share clk
interface fcad_addr_if;
	logic [15:0] logical;
	logic [9:0] page;
	logic ext_active;
	logic [7:0] segment;
	logic [23:0] physical;
	modport former (input logical, input page, input ext_active,
		input segment, output physical);
	modport user (output logical, output page, output ext_active,
		output segment, input physical);
endinterface

// ---- fcad_addr_former.sv ----
// forms the physical data address from a logical one
// assumes the page pointer already chosen by the caller
`include "fcad_params.svh"
module fcad_addr_former (
	fcad_addr_if.former a
);
	// segment prefix overrides page pointer formation
	always_comb begin
		if (a.ext_active) begin
			a.physical = {a.segment, a.logical};
		end else begin
			a.physical = {a.page, a.logical[`FCAD_OFS_W-1:0]};
		end
	end
endmodule

// ---- fcad_top.sv ----
// flash command interface front end: unlock decode and range check
// assumes cpu write strobes synchronous to clk, one cycle each
`include "fcad_params.svh"
// How it works
// - command offset compare uses bits 13:0 only
// - bits 15:14 pick a page pointer giving upper 10 bits
// - first unlock step is A8 written at offset 1554
// - second unlock step is 54 at 2AA8, only after first
// - third cycle F0 resets to read mode, address ignored
// - third cycle A0 and 80 are selectors, low byte only
// - A0 selects programming; next write starts it
// - 80 begins the block erase sequence
// - segment prefix gives 8-bit segment for next one to four instructions
module fcad_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [15:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [9:0] data_page_pointer0,
	input wire logic [9:0] data_page_pointer1,
	input wire logic [9:0] data_page_pointer2,
	input wire logic [9:0] data_page_pointer3,
	input wire logic extended_segment_prefix,
	input wire logic [7:0] prefix_segment,
	input wire logic [2:0] prefix_length,
	input wire logic instr_done,
	input wire logic [23:0] flash_base,
	input wire logic [23:0] flash_limit,
	output logic [2:0] seq_state,
	output logic prog_start,
	output logic [23:0] prog_addr,
	output logic [15:0] prog_data,
	output logic erase_setup,
	output logic read_mode,
	output logic [23:0] last_phys
);
	fcad_pkg::fcad_state_t state;
	fcad_pkg::fcad_state_t next_state;
	logic [2:0] ext_left;
	logic [7:0] ext_seg;
	logic [9:0] selected_page_pointer;
	logic in_range;
	logic [7:0] code;
	logic [13:0] ofs;
	fcad_addr_if ai ();

	fcad_addr_former u_former (.a(ai));

	// pick the page pointer by logical bits 15:14
	always_comb begin
		unique case (wr_addr[`FCAD_PAGE_SEL_HI:`FCAD_PAGE_SEL_LO])
			2'h0: selected_page_pointer = data_page_pointer0;
			2'h1: selected_page_pointer = data_page_pointer1;
			2'h2: selected_page_pointer = data_page_pointer2;
			2'h3: selected_page_pointer = data_page_pointer3;
		endcase
	end

	assign ai.logical = wr_addr;
	assign ai.page = selected_page_pointer;
	assign ai.ext_active = (ext_left != 3'h0);
	assign ai.segment = ext_seg;

	// writes outside the mapped flash reach only last_phys, never the sequence or programming
	assign in_range = (ai.physical >= flash_base) &&
		(ai.physical <= flash_limit);
	assign code = wr_data[7:0];
	assign ofs = wr_addr[`FCAD_OFS_W-1:0];

	// prefix window counts completed instructions
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_left <= 3'h0;
			ext_seg <= 8'h00;
		end else if (extended_segment_prefix) begin
			ext_seg <= prefix_segment;
			if (prefix_length == 3'h0) begin
				ext_left <= 3'h1;
			end else if (prefix_length > `FCAD_EXTENDED_SEGMENT_PREFIX_MAX) begin
				ext_left <= `FCAD_EXTENDED_SEGMENT_PREFIX_MAX;
			end else begin
				ext_left <= prefix_length;
			end
		end else if (instr_done && ext_left != 3'h0) begin
			ext_left <= ext_left - 3'h1;
		end
	end

	// unlock and command decode
	always_comb begin
		next_state = state;
		if (wr_en && in_range) begin
			unique case (state)
				fcad_pkg::FCAD_READ, fcad_pkg::FCAD_PROG,
				fcad_pkg::FCAD_ERASE: begin
					if (ofs == `FCAD_UNLOCK1_OFS &&
						code == `FCAD_UNLOCK1_DATA) begin
						next_state = fcad_pkg::FCAD_UNL1;
					end else begin
						next_state = fcad_pkg::FCAD_READ;
					end
				end
				fcad_pkg::FCAD_UNL1: begin
					if (ofs == `FCAD_UNLOCK2_OFS &&
						code == `FCAD_UNLOCK2_DATA) begin
						next_state = fcad_pkg::FCAD_UNL2;
					end else begin
						next_state = fcad_pkg::FCAD_READ;
					end
				end
				fcad_pkg::FCAD_UNL2: begin
					if (code == `FCAD_CODE_PROG) begin
						next_state = fcad_pkg::FCAD_PROG;
					end else if (code == `FCAD_CODE_ERASE) begin
						next_state = fcad_pkg::FCAD_ERASE;
					end else begin
						next_state = fcad_pkg::FCAD_READ;
					end
				end
				default: next_state = fcad_pkg::FCAD_READ;
			endcase
		end
	end

	// sequence state register
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= fcad_pkg::FCAD_READ;
		end else begin
			state <= next_state;
		end
	end

	// the write after a program selector starts programming
	always_ff @(posedge clk) begin
		if (rst) begin
			prog_start <= 1'b0;
			prog_addr <= `FCAD_FLASH_BASE_RST;
			prog_data <= 16'h0000;
		end else begin
			prog_start <= wr_en && in_range &&
				state == fcad_pkg::FCAD_PROG;
			if (wr_en && in_range && state == fcad_pkg::FCAD_PROG) begin
				prog_addr <= ai.physical;
				prog_data <= wr_data;
			end
		end
	end

	// visible status of the decoder
	always_ff @(posedge clk) begin
		if (rst) begin
			seq_state <= 3'h0;
			erase_setup <= 1'b0;
			read_mode <= 1'b1;
			last_phys <= `FCAD_FLASH_BASE_RST;
		end else begin
			seq_state <= next_state;
			erase_setup <= next_state == fcad_pkg::FCAD_ERASE;
			read_mode <= next_state == fcad_pkg::FCAD_READ;
			if (wr_en) begin
				last_phys <= ai.physical;
			end
		end
	end

	// unlock step 1 starts from read, program or erase-setup state
	chk_unlock_first: assert property (@(posedge clk)
		disable iff (rst)
		state != fcad_pkg::FCAD_UNL1 && state != fcad_pkg::FCAD_UNL2 &&
		wr_en && in_range && ofs == `FCAD_UNLOCK1_OFS &&
		code == `FCAD_UNLOCK1_DATA |=> state == fcad_pkg::FCAD_UNL1)
		else $error("first unlock step not taken");

	// unlock step 2 is only reachable through step 1
	chk_unlock_second: assert property (@(posedge clk)
		disable iff (rst)
		state == fcad_pkg::FCAD_UNL2 |-> $past(state) == fcad_pkg::FCAD_UNL1
		|| $past(state) == fcad_pkg::FCAD_UNL2)
		else $error("second step reached without first");

	// address bits above the offset do not block step 2 while the write stays in range
	chk_high_bits_ignored: assert property (@(posedge clk)
		disable iff (rst)
		state == fcad_pkg::FCAD_UNL1 && wr_en && in_range &&
		wr_addr[`FCAD_OFS_W-1:0] == `FCAD_UNLOCK2_OFS &&
		code == `FCAD_UNLOCK2_DATA |=> state == fcad_pkg::FCAD_UNL2)
		else $error("second step lost on high address bits");

	// read/reset code is back in read mode on the next cycle
	chk_reset_code: assert property (@(posedge clk)
		disable iff (rst)
		state == fcad_pkg::FCAD_UNL2 && wr_en && in_range &&
		code == `FCAD_CODE_RESET
		|=> read_mode && state == fcad_pkg::FCAD_READ)
		else $error("read reset not honoured");

	// program selector arms programming
	chk_selector_codes: assert property (@(posedge clk)
		disable iff (rst)
		state == fcad_pkg::FCAD_UNL2 && wr_en && in_range &&
		code == `FCAD_CODE_PROG |=> state == fcad_pkg::FCAD_PROG)
		else $error("program selector missed");

	// write after the selector launches programming with its data
	chk_prog_start: assert property (@(posedge clk)
		disable iff (rst)
		state == fcad_pkg::FCAD_PROG && wr_en && in_range
		|=> prog_start && prog_data == $past(wr_data))
		else $error("programming not started");

	// erase selector raises erase setup and leaves read mode
	chk_erase_setup: assert property (@(posedge clk)
		disable iff (rst)
		state == fcad_pkg::FCAD_UNL2 && wr_en && in_range &&
		code == `FCAD_CODE_ERASE |=> erase_setup && !read_mode)
		else $error("erase setup missed");

	// wrong second step drops the partial sequence
	chk_mismatch_abort: assert property (@(posedge clk)
		disable iff (rst)
		state == fcad_pkg::FCAD_UNL1 && wr_en && in_range &&
		code != `FCAD_UNLOCK2_DATA |=> state == fcad_pkg::FCAD_READ)
		else $error("bad step not abandoned");

	// page pointer 0 supplies the upper bits outside a prefix window
	chk_page_form: assert property (@(posedge clk)
		disable iff (rst)
		wr_en && ext_left == 3'h0 &&
		wr_addr[`FCAD_PAGE_SEL_HI:`FCAD_PAGE_SEL_LO] == 2'h0
		|=> last_phys == {$past(data_page_pointer0),
		$past(wr_addr[`FCAD_OFS_W-1:0])})
		else $error("page address wrongly formed");

	// a write right after a prefix uses the prefix segment
	chk_prefix_form: assert property (@(posedge clk)
		disable iff (rst)
		extended_segment_prefix ##1 wr_en
		|=> last_phys[23:16] == $past(prefix_segment, 2))
		else $error("segment prefix not applied");

	// writes outside the mapped flash leave the sequence untouched
	chk_range_refused: assert property (@(posedge clk)
		disable iff (rst)
		wr_en && !in_range |=> state == $past(state))
		else $error("out-of-range write changed the sequence");
endmodule

// ---- fcad_cpu_model.sv ----
// cpu-side model that issues indirect command writes, one cycle each
// assumes clk is the decoder clock; the bench calls the put task
module fcad_cpu_model (
	input wire logic clk,
	output logic wr_en,
	output logic [15:0] wr_addr,
	output logic [15:0] wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		wr_en = 1'b0;
		wr_addr = 16'h0000;
		wr_data = 16'h0000;
	end
	// one register-indirect write; lines show inverse once released
	task automatic put(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the flash command address decode block
// assumes the cpu model drives the write port; all else driven here
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr_en;
	logic [15:0] wr_addr;
	logic [15:0] wr_data;
	logic [9:0] dpp0 = 10'h008;
	logic [9:0] dpp1 = 10'h3FF;
	logic [9:0] dpp2 = 10'h010;
	logic [9:0] dpp3 = 10'h00C;
	logic [2:0] plen = 3'h2;
	logic ext = 1'b0;
	logic [7:0] seg = 8'h03;
	logic done = 1'b0;
	logic [2:0] seq_state;
	logic prog_start;
	logic [23:0] prog_addr;
	logic [15:0] prog_data;
	logic erase_setup;
	logic read_mode;
	logic [23:0] last_phys;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	// 100 MHz clock
	always #5 clk = ~clk;
	fcad_cpu_model cpu (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data));
	fcad_top DUT (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .data_page_pointer0(dpp0),
		.data_page_pointer1(dpp1), .data_page_pointer2(dpp2),
		.data_page_pointer3(dpp3), .extended_segment_prefix(ext),
		.prefix_segment(seg), .prefix_length(plen), .instr_done(done),
		.flash_base(24'h000000), .flash_limit(24'h07FFFF),
		.seq_state(seq_state), .prog_start(prog_start),
		.prog_addr(prog_addr), .prog_data(prog_data),
		.erase_setup(erase_setup), .read_mode(read_mode),
		.last_phys(last_phys));
	task automatic chk(string n, logic [23:0] e, logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// both unlock steps, page select bits set by hi
	task automatic unl(input logic [15:0] hi);
		cpu.put(hi | 16'h1554, 16'h00A8);
		#1 chk("state", 24'h1, {21'h0, seq_state});
		chk("read_mode", 24'h0, {23'h0, read_mode});
		cpu.put(hi | 16'h2AA8, 16'h0054);
		#1 chk("state", 24'h2, {21'h0, seq_state});
	endtask
	task automatic t_prog;
		unl(16'h0000);
		cpu.put(16'h1554, 16'hFFA0);
		#1 chk("state", 24'h3, {21'h0, seq_state});
		cpu.put(16'h0123, 16'hBEEF);
		#1 chk("prog_start", 24'h1, {23'h0, prog_start});
		chk("prog_addr", 24'h020123, prog_addr);
		chk("prog_data", 24'h00BEEF, {8'h0, prog_data});
	endtask
	// page pointer 3 carries the unlock writes here
	task automatic t_reset;
		unl(16'hC000);
		chk("last_phys", 24'h032AA8, last_phys);
		cpu.put(16'h0000, 16'h12F0);
		#1 chk("read_mode", 24'h1, {23'h0, read_mode});
		chk("state", 24'h0, {21'h0, seq_state});
	endtask
	// page pointer 2 carries the unlock writes here
	task automatic t_erase;
		unl(16'h8000);
		chk("last_phys", 24'h042AA8, last_phys);
		cpu.put(16'h0777, 16'h0080);
		#1 chk("erase_setup", 24'h1, {23'h0, erase_setup});
		chk("state", 24'h4, {21'h0, seq_state});
	endtask
	task automatic t_abandon;
		cpu.put(16'h2AA8, 16'h0054);
		#1 chk("state", 24'h0, {21'h0, seq_state});
		cpu.put(16'h1554, 16'h00A8);
		cpu.put(16'h2AA8, 16'h0055);
		#1 chk("state", 24'h0, {21'h0, seq_state});
		chk("read_mode", 24'h1, {23'h0, read_mode});
	endtask
	task automatic t_range;
		cpu.put(16'h5554, 16'h00A8);
		#1 chk("state", 24'h0, {21'h0, seq_state});
		chk("last_phys", 24'hFFD554, last_phys);
	endtask
	// prefix covers two instructions; write lands the cycle after it
	task automatic t_prefix;
		@(posedge clk);
		ext <= 1'b1;
		fork
			begin
				@(posedge clk);
				ext <= 1'b0;
			end
			cpu.put(16'h1234, 16'h0000);
		join
		#1 chk("last_phys", 24'h031234, last_phys);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		cpu.put(16'h0010, 16'h0000);
		#1 chk("last_phys", 24'h030010, last_phys);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		cpu.put(16'h0010, 16'h0000);
		#1 chk("last_phys", 24'h020010, last_phys);
	endtask
	task automatic summarize;
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			summarize();
		end
	end
	// reset then scenarios in turn
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_prog();
		t_reset();
		t_erase();
		t_abandon();
		t_range();
		t_prefix();
		summarize();
	end
endmodule
